// ---- design/sbr_pkg.sv ----
package sbr_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int unsigned ADDR_WIDTH = 3;

  localparam logic [2:0] ADDR_TRANSMIT_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_RECEIVE_CONTROL  = 3'h1;
  localparam logic [2:0] ADDR_RATE_CONTROL     = 3'h2;
  localparam logic [2:0] ADDR_DIVISOR_HIGH     = 3'h3;
  localparam logic [2:0] ADDR_DIVISOR_LOW      = 3'h4;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned TXC_SYNC_MODE_BIT   = 4;
  localparam int unsigned TXC_HIGH_SPEED_BIT  = 2;
  localparam int unsigned RXC_PORT_ENABLE_BIT = 7;
  localparam int unsigned RTC_IDLE_BIT        = 6;
  localparam int unsigned RTC_WIDE_BIT        = 3;

  // ==========================================================================
  // Writable masks, read-only constants and reset values
  // ==========================================================================
  localparam logic [7:0] TXC_WRITE_MASK = 8'hfd;
  localparam logic [7:0] TXC_FIXED_ONES = 8'h02;
  localparam logic [7:0] RXC_WRITE_MASK = 8'hf8;
  localparam logic [7:0] RTC_WRITE_MASK = 8'h1b;

  localparam logic [7:0] TXC_RESET      = 8'h00;
  localparam logic [7:0] RXC_RESET      = 8'h00;
  localparam logic [7:0] RTC_RESET      = 8'h10;
  localparam logic [7:0] DIVISOR_RESET  = 8'h00;

  // ==========================================================================
  // Prescale counts, less one, per rate formula
  // ==========================================================================
  localparam logic [5:0] SCALE_64_LAST = 6'h3f;
  localparam logic [5:0] SCALE_16_LAST = 6'h0f;
  localparam logic [5:0] SCALE_4_LAST  = 6'h03;

  // Receive pin idles high.
  localparam logic LINE_IDLE_LEVEL = 1'b1;

endpackage : sbr_pkg

// ---- design/sbr_rx_sampler.sv ----
`timescale 1ns/1ps
`default_nettype none

module sbr_rx_sampler (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Pin and sample strobe
  input  wire logic pin_i,
  input  wire logic strobe_i,
  // Voted level
  output logic      level_o
);

  logic       sync_a;
  logic       sync_b;
  logic       sync_c;
  logic       clean;
  logic [2:0] samples;
  logic       next_clean;
  logic [2:0] next_samples;
  logic       next_level;

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Only the second and third stages are compared, so a metastable first
  // stage never reaches the vote.
  always_comb begin
    next_clean   = (sync_b == sync_c) ? sync_c : clean;
    next_samples = strobe_i ? {samples[1:0], clean} : samples;
    next_level   = (samples[0] & samples[1]) | (samples[0] & samples[2]) |
                   (samples[1] & samples[2]);
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_a  <= sbr_pkg::LINE_IDLE_LEVEL;
      sync_b  <= sbr_pkg::LINE_IDLE_LEVEL;
      sync_c  <= sbr_pkg::LINE_IDLE_LEVEL;
      clean   <= sbr_pkg::LINE_IDLE_LEVEL;
      samples <= {3{sbr_pkg::LINE_IDLE_LEVEL}};
      level_o <= sbr_pkg::LINE_IDLE_LEVEL;
    end else begin
      sync_a  <= pin_i;
      sync_b  <= sync_a;
      sync_c  <= sync_b;
      clean   <= next_clean;
      samples <= next_samples;
      level_o <= next_level;
    end
  end

endmodule : sbr_rx_sampler

`default_nettype wire

// ---- design/sbr_rate_generator.sv ----
// Function
// - Divider runs on system clock, halts in sleep.
// - Receive level decided by three-sample majority.
// - Async narrow low-speed divides by 64(n+1).
// - Divisor is high byte over low byte.
// - Divisor write clears the divider timer.
// - Reset selects narrow divisor, high byte ignored.
// - Idle flag one unless receiving a character.
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module sbr_rate_generator #(
  parameter int unsigned DIVISOR_WIDTH = 16
) (
  // Clock and reset
  input  wire logic       REF_CLK_I,
  input  wire logic       RESET_I,
  // Register port
  input  wire logic [2:0] ADDR_I,
  input  wire logic [7:0] WR_DATA_I,
  input  wire logic       WR_STROBE_I,
  input  wire logic       RD_STROBE_I,
  output logic      [7:0] RD_DATA_O,
  // Power management
  input  wire logic       SLEEP_I,
  // Shift logic side
  input  wire logic       RX_BUSY_I,
  output logic            SAMPLE_TICK_O,
  output logic            BIT_TICK_O,
  output logic            RX_LEVEL_O,
  output logic            RECEIVER_IDLE_O,
  output logic            SYNC_MODE_O,
  output logic            PORT_ENABLE_O,
  // Receive pin
  input  wire logic       RX_PIN_I
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [7:0]               transmit_control;
  logic [7:0]               receive_control;
  logic [7:0]               rate_control;
  logic [7:0]               divisor_high_byte;
  logic [7:0]               divisor_low_byte;
  logic                     receiver_idle_flag;
  logic [DIVISOR_WIDTH-1:0] timer;
  logic [5:0]               phase;

  logic [7:0]               next_transmit_control;
  logic [7:0]               next_receive_control;
  logic [7:0]               next_rate_control;
  logic [7:0]               next_divisor_high_byte;
  logic [7:0]               next_divisor_low_byte;
  logic                     next_receiver_idle_flag;
  logic [7:0]               next_rd_data;
  logic [DIVISOR_WIDTH-1:0] next_timer;
  logic [5:0]               next_phase;
  logic                     next_sample_tick;
  logic                     next_bit_tick;

  logic                     wide_divisor_select;
  logic                     high_speed_select;
  logic                     sync_mode;
  logic [DIVISOR_WIDTH-1:0] divisor;
  logic [5:0]               scale_last;
  logic                     divisor_write;

  assign wide_divisor_select = rate_control[sbr_pkg::RTC_WIDE_BIT];
  assign high_speed_select   = transmit_control[sbr_pkg::TXC_HIGH_SPEED_BIT];
  assign sync_mode           = transmit_control[sbr_pkg::TXC_SYNC_MODE_BIT];

  // ==========================================================================
  // Register file
  // ==========================================================================
  always_comb begin
    next_transmit_control  = transmit_control;
    next_receive_control   = receive_control;
    next_rate_control      = rate_control;
    next_divisor_high_byte = divisor_high_byte;
    next_divisor_low_byte  = divisor_low_byte;
    next_rd_data           = 8'h00;
    divisor_write          = 1'b0;
    if (WR_STROBE_I) begin
      case (ADDR_I)
        sbr_pkg::ADDR_TRANSMIT_CONTROL: begin
          next_transmit_control = WR_DATA_I & sbr_pkg::TXC_WRITE_MASK;
        end
        sbr_pkg::ADDR_RECEIVE_CONTROL: begin
          next_receive_control = WR_DATA_I & sbr_pkg::RXC_WRITE_MASK;
        end
        sbr_pkg::ADDR_RATE_CONTROL: begin
          next_rate_control = WR_DATA_I & sbr_pkg::RTC_WRITE_MASK;
        end
        sbr_pkg::ADDR_DIVISOR_HIGH: begin
          next_divisor_high_byte = WR_DATA_I;
          divisor_write          = 1'b1;
        end
        sbr_pkg::ADDR_DIVISOR_LOW: begin
          next_divisor_low_byte = WR_DATA_I;
          divisor_write         = 1'b1;
        end
        default: begin
        end
      endcase
    end
    if (RD_STROBE_I) begin
      case (ADDR_I)
        sbr_pkg::ADDR_TRANSMIT_CONTROL: begin
          next_rd_data = transmit_control | sbr_pkg::TXC_FIXED_ONES;
        end
        sbr_pkg::ADDR_RECEIVE_CONTROL: begin
          next_rd_data = receive_control;
        end
        sbr_pkg::ADDR_RATE_CONTROL: begin
          next_rd_data = rate_control;
          next_rd_data[sbr_pkg::RTC_IDLE_BIT] = receiver_idle_flag;
        end
        sbr_pkg::ADDR_DIVISOR_HIGH: begin
          next_rd_data = divisor_high_byte;
        end
        sbr_pkg::ADDR_DIVISOR_LOW: begin
          next_rd_data = divisor_low_byte;
        end
        default: begin
          next_rd_data = 8'h00;
        end
      endcase
    end
  end

  // The flag follows the shift logic with one cycle of delay.
  always_comb begin
    next_receiver_idle_flag = ~RX_BUSY_I;
  end

  // ==========================================================================
  // Rate divider
  // ==========================================================================
  always_comb begin
    if (wide_divisor_select) begin
      divisor = {divisor_high_byte, divisor_low_byte};
    end else begin
      divisor = {8'h00, divisor_low_byte};
    end
    if (sync_mode || (high_speed_select && wide_divisor_select)) begin
      scale_last = sbr_pkg::SCALE_4_LAST;
    end else if (high_speed_select || wide_divisor_select) begin
      scale_last = sbr_pkg::SCALE_16_LAST;
    end else begin
      scale_last = sbr_pkg::SCALE_64_LAST;
    end
    next_timer       = timer;
    next_phase       = phase;
    next_sample_tick = 1'b0;
    next_bit_tick    = 1'b0;
    // A new divisor restarts the period at once instead of finishing the
    // old count, which could take up to 65536 cycles at the wide setting.
    if (divisor_write) begin
      next_timer = '0;
      next_phase = 6'h00;
    end else if (SLEEP_I) begin
      next_timer = timer;
    end else if (timer >= divisor) begin
      next_timer       = '0;
      next_sample_tick = 1'b1;
      if (phase >= scale_last) begin
        next_phase    = 6'h00;
        next_bit_tick = 1'b1;
      end else begin
        next_phase = phase + 6'h01;
      end
    end else begin
      next_timer = timer + 1'b1;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      transmit_control   <= sbr_pkg::TXC_RESET;
      receive_control    <= sbr_pkg::RXC_RESET;
      rate_control       <= sbr_pkg::RTC_RESET;
      divisor_high_byte  <= sbr_pkg::DIVISOR_RESET;
      divisor_low_byte   <= sbr_pkg::DIVISOR_RESET;
      receiver_idle_flag <= 1'b1;
      timer              <= '0;
      phase              <= 6'h00;
      RD_DATA_O          <= 8'h00;
      SAMPLE_TICK_O      <= 1'b0;
      BIT_TICK_O         <= 1'b0;
      RECEIVER_IDLE_O    <= 1'b1;
      SYNC_MODE_O        <= 1'b0;
      PORT_ENABLE_O      <= 1'b0;
    end else begin
      transmit_control   <= next_transmit_control;
      receive_control    <= next_receive_control;
      rate_control       <= next_rate_control;
      divisor_high_byte  <= next_divisor_high_byte;
      divisor_low_byte   <= next_divisor_low_byte;
      receiver_idle_flag <= next_receiver_idle_flag;
      timer              <= next_timer;
      phase              <= next_phase;
      RD_DATA_O          <= next_rd_data;
      SAMPLE_TICK_O      <= next_sample_tick;
      BIT_TICK_O         <= next_bit_tick;
      RECEIVER_IDLE_O    <= next_receiver_idle_flag;
      SYNC_MODE_O        <= next_transmit_control[sbr_pkg::TXC_SYNC_MODE_BIT];
      PORT_ENABLE_O      <=
        next_receive_control[sbr_pkg::RXC_PORT_ENABLE_BIT];
    end
  end

  // ==========================================================================
  // Receive pin vote
  // ==========================================================================
  // Samples are taken once per divider period, so the vote spans three
  // periods; a glitch no longer than one period cannot flip the level.
  sbr_rx_sampler u_rx_sampler (
    .clk_i    (REF_CLK_I),
    .rst_i    (RESET_I),
    .pin_i    (RX_PIN_I),
    .strobe_i (SAMPLE_TICK_O),
    .level_o  (RX_LEVEL_O)
  );

endmodule : sbr_rate_generator

`default_nettype wire

// ---- test/sbr_shift_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// Receive shift logic
module sbr_shift_model (
  // Generator side
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic bit_tick_i,
  input  wire logic level_i,
  output logic      busy_o
);
  logic [3:0] bits;
  // A low line starts a ten-bit frame; no stop-bit check is made.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bits <= 4'h0;
    end else if (bits == 4'h0) begin
      bits <= level_i ? 4'h0 : 4'ha;
    end else if (bit_tick_i) begin
      bits <= bits - 4'h1;
    end
  end
  assign busy_o = (bits != 4'h0);
endmodule : sbr_shift_model
`default_nettype wire

// ---- test/sbr_rate_generator_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module sbr_checker (
  // Design ports
  input wire logic       REF_CLK_I,
  input wire logic       RESET_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [7:0] WR_DATA_I,
  input wire logic       WR_STROBE_I,
  input wire logic       RD_STROBE_I,
  input wire logic [7:0] RD_DATA_O,
  input wire logic       SLEEP_I,
  input wire logic       RX_BUSY_I,
  input wire logic       SAMPLE_TICK_O,
  input wire logic       BIT_TICK_O,
  input wire logic       RX_LEVEL_O,
  input wire logic       RECEIVER_IDLE_O,
  input wire logic       SYNC_MODE_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);
  sequence s_div_wr;
    WR_STROBE_I && ADDR_I inside {3'h3, 3'h4};
  endsequence
  sequence s_txc_wr;
    WR_STROBE_I && ADDR_I == 3'h0 ##1 !WR_STROBE_I;
  endsequence
  a_div_clear: assert property (s_div_wr |-> ##2 (!BIT_TICK_O)[*2])
    else $error("bit tick soon after divisor write");
  a_mode_copy: assert property (
    s_txc_wr |=> SYNC_MODE_O == $past(WR_DATA_I[4], 2))
    else $error("sync mode output stale");
  a_idle_follow: assert property (
    !$past(RESET_I) |-> RECEIVER_IDLE_O == !$past(RX_BUSY_I))
    else $error("idle flag not busy inverse");
  a_idle_read: assert property (
    RD_STROBE_I && ADDR_I == 3'h2 |=>
    RD_DATA_O[6] == $past(RECEIVER_IDLE_O))
    else $error("idle bit read wrong");
  a_unmapped_zero: assert property (RD_STROBE_I && ADDR_I > 3'h4 |=>
    RD_DATA_O == 8'h00)
    else $error("unmapped read not zero");
  a_read_quiet: assert property (!RD_STROBE_I |=> RD_DATA_O == 8'h00)
    else $error("read data outside read slot");
  a_bit_sample: assert property (BIT_TICK_O |-> SAMPLE_TICK_O)
    else $error("bit tick without sample tick");
  a_sleep_still: assert property (SLEEP_I [*2] |-> !SAMPLE_TICK_O)
    else $error("tick while asleep");
  a_level_tick: assert property (
    $changed(RX_LEVEL_O) |-> $past(SAMPLE_TICK_O) ||
    $past(SAMPLE_TICK_O, 2) || $past(SAMPLE_TICK_O, 3))
    else $error("level moved without sample");
endmodule : sbr_checker
bind sbr_rate_generator sbr_checker u_chk (.REF_CLK_I(REF_CLK_I),
  .RESET_I(RESET_I), .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I),
  .WR_STROBE_I(WR_STROBE_I), .RD_STROBE_I(RD_STROBE_I),
  .RD_DATA_O(RD_DATA_O), .SLEEP_I(SLEEP_I), .RX_BUSY_I(RX_BUSY_I),
  .SAMPLE_TICK_O(SAMPLE_TICK_O), .BIT_TICK_O(BIT_TICK_O),
  .RX_LEVEL_O(RX_LEVEL_O), .RECEIVER_IDLE_O(RECEIVER_IDLE_O),
  .SYNC_MODE_O(SYNC_MODE_O));
`default_nettype wire

// ---- test/sbr_rate_generator_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench
module sbr_rate_generator_tb;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr_s = 1'b0;
  logic       rd_s = 1'b0;
  logic       sleep = 1'b0;
  logic       pin = 1'b1;
  logic       busy, stick, btick, lvl, idle, sync, pen;
  logic [7:0] rdata, lo, hi, v;
  int         n_mismatch = 0;
  int         checks_done = 0;
  int         cyc = 0;
  int         c, n;
  always #25 clk = ~clk;
  sbr_rate_generator DUT (.REF_CLK_I(clk), .RESET_I(rst), .ADDR_I(addr),
    .WR_DATA_I(wdata), .WR_STROBE_I(wr_s), .RD_STROBE_I(rd_s),
    .RD_DATA_O(rdata), .SLEEP_I(sleep), .RX_BUSY_I(busy),
    .SAMPLE_TICK_O(stick), .BIT_TICK_O(btick), .RX_LEVEL_O(lvl),
    .RECEIVER_IDLE_O(idle), .SYNC_MODE_O(sync), .PORT_ENABLE_O(pen),
    .RX_PIN_I(pin));
  sbr_shift_model PM (.clk_i(clk), .rst_i(rst), .bit_tick_i(btick),
    .level_i(lvl), .busy_o(busy));
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_cnt(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk_cnt
  function automatic int kf(logic s, logic h, logic w);
    return (s || (h && w)) ? 4 : (h ^ w) ? 16 : 64;
  endfunction : kf
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk_byte(rdata, e);
    @(posedge clk);
  endtask : rd_chk
  // Spacing of two ticks; a missing tick shows up as a wrong count.
  task automatic gap(input logic use_bit, output int cnt);
    int seen;
    seen = 0;
    cnt = 0;
    while (seen < 2 && cnt < 9000) begin
      @(negedge clk);
      if (seen == 1) cnt++;
      if ((use_bit ? btick : stick) === 1'b1) seen++;
    end
    @(posedge clk);
  endtask : gap
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'ha61d42fb));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 8; a++) begin
      rd_chk(a[2:0], a == 0 ? 8'h02 : a == 2 ? 8'h50 : 8'h00);
    end
    for (int a = 0; a < 7; a++) begin
      v = 8'($urandom);
      wr(a[2:0], v);
      lo = a == 0 ? 8'hfd : a == 1 ? 8'hf8 : a == 2 ? 8'h1b : 8'hff;
      hi = a == 0 ? 8'h02 : a == 2 ? 8'h40 : 8'h00;
      rd_chk(a[2:0], a > 4 ? 8'h00 : (v & lo) | hi);
      if (a == 1) chk_byte({7'h0, pen}, {7'h0, v[7]});
    end
    for (int m = 0; m < 8; m++) begin
      hi = m[0] ? 8'($urandom_range(1)) : 8'($urandom);
      lo = 8'($urandom_range(7));
      wr(3'h0, {3'h0, m[2], 1'b0, m[1], 2'h0});
      wr(3'h2, {4'h0, m[0], 3'h0});
      wr(3'h3, hi);
      wr(3'h4, lo);
      c = m[0] ? {hi, lo} + 1 : lo + 1;
      gap(1'b0, n);
      chk_cnt(n, c);
      gap(1'b1, n);
      chk_cnt(n, c * kf(m[2], m[1], m[0]));
    end
    wr(3'h3, 8'h00);
    wr(3'h4, 8'hc8);
    repeat (60) @(posedge clk);
    wr(3'h4, 8'h02);
    c = 0;
    while (stick !== 1'b1 && c < 300) begin
      @(negedge clk);
      c++;
    end
    chk_cnt(c < 4, 1);
    @(posedge clk);
    sleep <= 1'b1;
    repeat (2) @(posedge clk);
    c = 0;
    repeat (40) begin
      @(negedge clk);
      c += (stick === 1'b1);
    end
    chk_cnt(c, 0);
    @(posedge clk);
    sleep <= 1'b0;
    gap(1'b0, n);
    chk_cnt(n, 3);
    wr(3'h4, 8'h07);
    wr(3'h2, 8'h00);
    pin <= 1'b0;
    repeat ($urandom_range(5, 2)) @(posedge clk);
    pin <= 1'b1;
    c = 0;
    repeat (40) begin
      @(negedge clk);
      c += (lvl === 1'b0);
    end
    chk_cnt(c, 0);
    @(posedge clk);
    pin <= 1'b0;
    repeat (60) @(posedge clk);
    @(negedge clk);
    chk_byte({7'h0, lvl}, 8'h00);
    chk_byte({6'h0, idle, sync}, 8'h01);
    @(posedge clk);
    rd_chk(3'h2, 8'h00);
    pin <= 1'b1;
    c = 0;
    while (idle !== 1'b1 && c < 2000) begin
      @(negedge clk);
      c++;
    end
    @(posedge clk);
    wr(3'h4, 8'h01);
    rd_chk(3'h2, 8'h40);
    wr(3'h1, 8'h80);
    chk_byte({7'h0, pen}, 8'h01);
    test_done();
  end
endmodule : sbr_rate_generator_tb
`default_nettype wire
